// file: hbt_regs.svh
`ifndef HBT_REGS_SVH
`define HBT_REGS_SVH
// What this block does
// - two triggers per hart, debug or machine
// - select picks trigger; data CSRs reach it
// - control kind field reads 2
// - hit response keeps only 0 or 1
// - load, store, fetch qualifiers limit matching
// - machine, supervisor, user qualifiers limit matching
// - range kind: exact, aligned, linked range
// - trailing ones in address encode range size
// - read-only largest range log, resets 4
// - widest range ignores only the low 4 address bits
// - link bit needs both triggers matching
// - timing and select bits read zero
// - address register full width read/write
// - breakpoint traps taken precisely
// - any byte of access inside range traps
// - debug hit leaves machine registers untouched
// - exception hit records cause and address
// - machine access to debug trigger is illegal
// - debug-owned trigger reads kind 0 in machine
// - debug entry saves program counter

// ----------------------------------------
// csr numbers of the trigger window
// ----------------------------------------
`define HBT_CSR_SELECT 12'h7a0
`define HBT_CSR_DATA1 12'h7a1
`define HBT_CSR_DATA2 12'h7a2
`define HBT_CSR_DATA3 12'h7a3

// ----------------------------------------
// control word field positions
// ----------------------------------------
`define HBT_F_LOAD 0
`define HBT_F_STORE 1
`define HBT_F_FETCH 2
`define HBT_F_USER 3
`define HBT_F_SUPER 4
`define HBT_F_MACH 6
`define HBT_F_MATCH 7
`define HBT_F_CHAIN 11
`define HBT_F_ACTION 12
`define HBT_F_TIMING 18
`define HBT_F_SELECT 19
`define HBT_F_MASKMAX 21
`define HBT_F_DMODE 27
`define HBT_F_TYPE 28

// ----------------------------------------
// field values and reset values
// ----------------------------------------
`define HBT_NTRIG 2
`define HBT_MASKMAX_RST 4
`define HBT_TYPE_NONE 4'h0
`define HBT_TYPE_ADDR 4'h2
`define HBT_ACT_EXC 6'h00
`define HBT_ACT_DBG 6'h01
`define HBT_MATCH_EQ 4'h0
`define HBT_MATCH_POW2 4'h1
`define HBT_MATCH_GE 4'h2
`define HBT_MATCH_LT 4'h3
`define HBT_CAUSE_BRK 32'h00000003
`define HBT_PRIV_U 2'h0
`define HBT_PRIV_S 2'h1
`define HBT_PRIV_M 2'h3
`endif

// file: hbt_pkg.sv
package hbt_pkg;

// ----------------------------------------
// access kinds from the pipeline
// ----------------------------------------
typedef enum logic [1:0] {
    HBT_LOAD,
    HBT_STORE,
    HBT_FETCH
} hbt_acc_e;

// ----------------------------------------
// stored part of one control register
// ----------------------------------------
typedef struct packed {
    logic dmode;      // owned by debug mode
    logic act_dbg;    // hit enters debug mode
    logic chain;      // linked to next trigger
    logic [3:0] kind; // range kind code
    logic m;          // machine qualifier
    logic s;          // supervisor qualifier
    logic u;          // user qualifier
    logic x;          // fetch qualifier
    logic w;          // store qualifier
    logic r;          // load qualifier
} hbt_ctrl_s;

endpackage

// file: hbt_warl.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbt_regs.svh"
// legalises a control write; illegal codes keep the old value
module hbt_warl (
    input wire hbt_pkg::hbt_ctrl_s old_ctrl, // current stored control
    input wire logic [31:0] wdata,           // csr write data
    input wire logic dbg_mode,               // writer is in debug mode
    output hbt_pkg::hbt_ctrl_s new_ctrl      // legal value to store
);
    import hbt_pkg::*;

    logic [5:0] act; // written response field
    logic [3:0] kind; // written range kind

    // ----------------------------------------
    // field legalisation
    // ----------------------------------------
    always_comb begin
        act = wdata[`HBT_F_ACTION +: 6];
        kind = wdata[`HBT_F_MATCH +: 4];
        new_ctrl = old_ctrl;
        new_ctrl.r = wdata[`HBT_F_LOAD];
        new_ctrl.w = wdata[`HBT_F_STORE];
        new_ctrl.x = wdata[`HBT_F_FETCH];
        new_ctrl.u = wdata[`HBT_F_USER];
        new_ctrl.s = wdata[`HBT_F_SUPER];
        new_ctrl.m = wdata[`HBT_F_MACH];
        new_ctrl.chain = wdata[`HBT_F_CHAIN];
        // only debug mode may claim or release a trigger
        if (dbg_mode) begin
            new_ctrl.dmode = wdata[`HBT_F_DMODE];
        end
        // unimplemented responses are dropped, old one stays
        if (act == `HBT_ACT_EXC || act == `HBT_ACT_DBG) begin
            new_ctrl.act_dbg = act[0];
        end
        // four kinds known; anything else is not retained
        if (kind <= `HBT_MATCH_LT) begin
            new_ctrl.kind = kind;
        end
        // timing and select have no storage at all
    end
endmodule
`default_nettype wire

// file: hbt_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbt_regs.svh"
// address compare and qualifiers of one trigger
module hbt_match #(
    parameter int MASKMAX = `HBT_MASKMAX_RST // log2 of widest range
) (
    input wire hbt_pkg::hbt_ctrl_s ctrl,  // trigger control
    input wire logic [31:0] taddr,        // trigger address register
    input wire logic acc_valid,           // access present
    input wire hbt_pkg::hbt_acc_e acc_type, // load, store or fetch
    input wire logic [1:0] acc_priv,      // privilege of access
    input wire logic [31:0] acc_first,    // first byte address
    input wire logic [31:0] acc_last,     // last byte address
    output logic hit                      // qualified match
);
    import hbt_pkg::*;

    logic [31:0] mask; // bytes ignored by aligned compare
    logic [31:0] cap; // widest mask allowed
    logic addr_ok; // address compare result
    logic type_ok; // access kind enabled
    logic priv_ok; // privilege enabled

    // ----------------------------------------
    // compare
    // ----------------------------------------
    always_comb begin
        cap = (32'h1 << MASKMAX) - 32'h1;
        // trailing ones plus their ending zero give the size
        mask = (taddr ^ (taddr + 32'h1)) & cap;
        case (ctrl.kind)
            // a byte inside a wide access still counts
            `HBT_MATCH_EQ: addr_ok = (acc_first <= taddr) && (taddr <= acc_last);
            `HBT_MATCH_POW2: addr_ok = (acc_first <= (taddr | mask)) &&
                                       (acc_last >= (taddr & ~mask));
            `HBT_MATCH_GE: addr_ok = acc_last >= taddr;
            `HBT_MATCH_LT: addr_ok = acc_first < taddr;
            default: addr_ok = 1'b0;
        endcase
        case (acc_type)
            HBT_LOAD: type_ok = ctrl.r;
            HBT_STORE: type_ok = ctrl.w;
            HBT_FETCH: type_ok = ctrl.x;
            default: type_ok = 1'b0;
        endcase
        case (acc_priv)
            `HBT_PRIV_U: priv_ok = ctrl.u;
            `HBT_PRIV_S: priv_ok = ctrl.s;
            `HBT_PRIV_M: priv_ok = ctrl.m;
            default: priv_ok = 1'b0;
        endcase
        hit = acc_valid && addr_ok && type_ok && priv_ok;
    end
endmodule
`default_nettype wire

// file: hbt_triggers.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbt_regs.svh"
// per-hart breakpoint trigger unit
module hbt_triggers #(
    parameter int NTRIG = `HBT_NTRIG,         // trigger count
    parameter int MASKMAX = `HBT_MASKMAX_RST  // log2 widest range
) (
    input wire logic clk,                   // core clock
    input wire logic rst,                   // async reset, high
    input wire logic csr_en,                // csr access strobe
    input wire logic csr_we,                // csr access writes
    input wire logic [11:0] csr_addr,       // csr number
    input wire logic [31:0] csr_wdata,      // csr write data
    input wire logic dbg_mode,              // hart is in debug mode
    input wire logic [1:0] priv_mode,       // current privilege
    input wire logic acc_valid,             // access to check
    input wire hbt_pkg::hbt_acc_e acc_type, // access kind
    input wire logic [31:0] acc_addr,       // access byte address
    input wire logic [1:0] acc_size,        // log2 access bytes
    input wire logic [31:0] acc_pc,         // pc of the access
    output logic [31:0] csr_rdata,          // csr read data
    output logic csr_illegal,               // access refused
    output logic trap_exc,                  // breakpoint exception
    output logic trap_dbg,                  // enter debug mode
    output logic trap_squash,               // kill the access
    output logic mcause_we,                 // write cause and tval
    output logic [31:0] mcause,             // cause value
    output logic [31:0] mtval,              // faulting address
    output logic [31:0] dpc                 // saved debug pc
);
    import hbt_pkg::*;

    localparam int SELW = (NTRIG > 1) ? $clog2(NTRIG) : 1; // select width

    // ----------------------------------------
    // whole state of the unit
    // ----------------------------------------
    typedef struct packed {
        logic [SELW-1:0] sel;              // visible trigger
        hbt_ctrl_s [NTRIG-1:0] ctrl;       // control per trigger
        logic [NTRIG-1:0][31:0] addr;      // address per trigger
        logic [31:0] rdata;                // read answer
        logic illegal;                     // refused access
        logic exc;                         // exception pulse
        logic dbg;                         // debug entry pulse
        logic squash;                      // kill pulse
        logic cause_we;                    // cause write pulse
        logic [31:0] cause;                // cause value
        logic [31:0] tval;                 // trap value
        logic [31:0] dpc;                  // debug pc
    } hbt_state_s;

    hbt_state_s s_r; // registered state
    hbt_state_s s_nxt; // next state

    logic [NTRIG-1:0] hit_raw; // qualified matches
    logic [NTRIG-1:0] fire; // matches after linking
    logic [NTRIG-1:0] want_dbg; // firing trigger wants debug
    logic [31:0] acc_last; // last byte of access
    logic sel_dmode; // visible trigger owned by debug
    logic hide; // machine view of debug trigger
    logic blocked; // machine access refused
    hbt_ctrl_s warl_ctrl; // legal control for write

    // ----------------------------------------
    // csr decode helpers
    // ----------------------------------------
    // any of the three data windows
    function automatic logic is_tdata(input logic [11:0] a);
        is_tdata = (a == `HBT_CSR_DATA1) || (a == `HBT_CSR_DATA2) ||
                   (a == `HBT_CSR_DATA3);
    endfunction

    // read image of one control register
    function automatic logic [31:0] ctrl_word(input hbt_ctrl_s c, input logic hid);
        logic [31:0] w;
        w = 32'h0;
        if (!hid) begin
            w[`HBT_F_TYPE +: 4] = `HBT_TYPE_ADDR;
            w[`HBT_F_MASKMAX +: 6] = 6'(MASKMAX);
            w[`HBT_F_DMODE] = c.dmode;
            w[`HBT_F_ACTION +: 6] = {5'h0, c.act_dbg};
            w[`HBT_F_CHAIN] = c.chain;
            w[`HBT_F_MATCH +: 4] = c.kind;
            w[`HBT_F_MACH] = c.m;
            w[`HBT_F_SUPER] = c.s;
            w[`HBT_F_USER] = c.u;
            w[`HBT_F_FETCH] = c.x;
            w[`HBT_F_STORE] = c.w;
            w[`HBT_F_LOAD] = c.r;
            // timing and select stay zero: fire before, address only
        end
        ctrl_word = w;
    endfunction

    // ----------------------------------------
    // access span and per-trigger compare
    // ----------------------------------------
    // last byte lets a wide access hit on any of its bytes
    assign acc_last = acc_addr + ((32'h1 << acc_size) - 32'h1);

    genvar gi;
    generate
        for (gi = 0; gi < NTRIG; gi++) begin : g_trig
            // one comparator per trigger
            hbt_match #(
                .MASKMAX(MASKMAX)
            ) u_match (
                .ctrl(s_r.ctrl[gi]),
                .taddr(s_r.addr[gi]),
                .acc_valid(acc_valid),
                .acc_type(acc_type),
                .acc_priv(priv_mode),
                .acc_first(acc_addr),
                .acc_last(acc_last),
                .hit(hit_raw[gi])
            );
            // a linked lower trigger only qualifies the next one
            if (gi == 0) begin : g_first
                assign fire[gi] = hit_raw[gi] && !s_r.ctrl[gi].chain && !dbg_mode;
            end else begin : g_rest
                assign fire[gi] = hit_raw[gi] && !s_r.ctrl[gi].chain && !dbg_mode &&
                                  (!s_r.ctrl[gi-1].chain || hit_raw[gi-1]);
            end
            assign want_dbg[gi] = s_r.ctrl[gi].act_dbg;
        end
    endgenerate

    // ----------------------------------------
    // control write legaliser
    // ----------------------------------------
    hbt_warl u_warl (
        .old_ctrl(s_r.ctrl[s_r.sel]),
        .wdata(csr_wdata),
        .dbg_mode(dbg_mode),
        .new_ctrl(warl_ctrl)
    );

    // ----------------------------------------
    // ownership checks
    // ----------------------------------------
    assign sel_dmode = s_r.ctrl[s_r.sel].dmode;
    assign hide = sel_dmode && !dbg_mode;
    assign blocked = csr_en && is_tdata(csr_addr) && hide;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        // pulses last one cycle
        s_nxt.exc = 1'b0;
        s_nxt.dbg = 1'b0;
        s_nxt.squash = 1'b0;
        s_nxt.cause_we = 1'b0;
        s_nxt.illegal = 1'b0;
        // read path, answered one cycle after the strobe
        if (csr_en) begin
            s_nxt.illegal = blocked;
            case (csr_addr)
                `HBT_CSR_SELECT: s_nxt.rdata = 32'(s_r.sel);
                `HBT_CSR_DATA1: s_nxt.rdata = ctrl_word(s_r.ctrl[s_r.sel], hide);
                `HBT_CSR_DATA2: s_nxt.rdata = hide ? 32'h0 : s_r.addr[s_r.sel];
                `HBT_CSR_DATA3: s_nxt.rdata = 32'h0;
                default: s_nxt.rdata = 32'h0;
            endcase
        end
        // write path; a refused write changes nothing
        if (csr_en && csr_we && !blocked) begin
            case (csr_addr)
                // indices of absent triggers are not held
                `HBT_CSR_SELECT: begin
                    if (csr_wdata < 32'(NTRIG)) begin
                        s_nxt.sel = csr_wdata[SELW-1:0];
                    end
                end
                `HBT_CSR_DATA1: s_nxt.ctrl[s_r.sel] = warl_ctrl;
                `HBT_CSR_DATA2: s_nxt.addr[s_r.sel] = csr_wdata;
                default: ;
            endcase
        end
        // debug entry wins over an exception in the same access
        if (|(fire & want_dbg)) begin
            // machine cause and tval stay untouched
            s_nxt.dbg = 1'b1;
            s_nxt.squash = 1'b1;
            s_nxt.dpc = acc_pc;
        end else if (|fire) begin
            s_nxt.exc = 1'b1;
            s_nxt.squash = 1'b1;
            s_nxt.cause_we = 1'b1;
            s_nxt.cause = `HBT_CAUSE_BRK;
            s_nxt.tval = acc_addr;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // qualifiers reset clear so no trigger fires before setup
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // outputs, all straight from the register
    // ----------------------------------------
    assign csr_rdata = s_r.rdata;
    assign csr_illegal = s_r.illegal;
    assign trap_exc = s_r.exc;
    assign trap_dbg = s_r.dbg;
    // squash is what keeps the trap precise in the pipeline
    assign trap_squash = s_r.squash;
    assign mcause_we = s_r.cause_we;
    assign mcause = s_r.cause;
    assign mtval = s_r.tval;
    assign dpc = s_r.dpc;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // tselect write of an absent index
    sequence s_bad_select;
        csr_en && csr_we && !blocked && csr_addr == `HBT_CSR_SELECT &&
        csr_wdata >= 32'(NTRIG);
    endsequence

    // control read by an owner
    sequence s_owner_read;
        csr_en && csr_addr == `HBT_CSR_DATA1 && !hide;
    endsequence

    // exception hit and its record
    sequence s_exc_hit;
        acc_valid && (|fire) && !(|(fire & want_dbg));
    endsequence

    sequence s_exc_record;
        trap_exc && trap_squash && mcause_we && mcause == `HBT_CAUSE_BRK;
    endsequence

    // debug hit and its record
    sequence s_dbg_hit;
        acc_valid && (|(fire & want_dbg));
    endsequence

    // index is warl
    select_hold_a: assert property (
        s_bad_select |=> $stable(s_r.sel))
        else $error("select took an absent index");

    // fixed type
    kind_reads_two_a: assert property (
        s_owner_read |=>
        csr_rdata[`HBT_F_TYPE +: 4] == `HBT_TYPE_ADDR)
        else $error("control kind not 2");

    // fixed limit
    maskmax_read_a: assert property (
        s_owner_read |=>
        csr_rdata[`HBT_F_MASKMAX +: 6] == 6'(MASKMAX))
        else $error("largest range field wrong");

    // no storage
    timing_zero_a: assert property (
        s_owner_read |=>
        csr_rdata[`HBT_F_SELECT:`HBT_F_TIMING] == 2'h0)
        else $error("timing or select not zero");

    action_reject_a: assert property (
        csr_en && csr_we && !blocked &&
        csr_addr == `HBT_CSR_DATA1 && csr_wdata[`HBT_F_ACTION +: 6] > `HBT_ACT_DBG
        |=> $stable(s_r.ctrl[s_r.sel].act_dbg))
        else $error("bad response value kept");

    hidden_illegal_a: assert property (
        csr_en && is_tdata(csr_addr) && hide
        |=> csr_illegal && $stable(s_r.addr) && $stable(s_r.ctrl))
        else $error("machine access to debug trigger");

    hidden_kind_a: assert property (
        csr_en && csr_addr == `HBT_CSR_DATA1 && hide
        |=> csr_rdata[`HBT_F_TYPE +: 4] == `HBT_TYPE_NONE)
        else $error("hidden trigger kind not 0");

    exc_record_a: assert property (
        s_exc_hit |=> s_exc_record ##0
        mtval == $past(acc_addr) ##1 !trap_exc || (|$past(fire)))
        else $error("exception record wrong");

    dbg_quiet_a: assert property (s_dbg_hit |=> trap_dbg && trap_squash &&
        !mcause_we && !trap_exc && $stable(mtval))
        else $error("debug hit touched machine state");

    // debug resume
    dpc_save_a: assert property (
        s_dbg_hit |=> dpc == $past(acc_pc))
        else $error("debug pc not saved");

    link_block_a: assert property (
        s_r.ctrl[0].chain && !hit_raw[0]
        |=> !trap_exc && !trap_dbg)
        else $error("linked trigger fired alone");

    debug_silent_a: assert property (dbg_mode |=> !trap_exc && !trap_dbg)
        else $error("trigger fired in debug mode");

    squash_pair_a: assert property (
        (trap_exc || trap_dbg) |-> trap_squash
        ##1 !trap_squash || $past(acc_valid))
        else $error("trap without squash");

    squash_only_a: assert property (trap_squash |-> trap_exc || trap_dbg)
        else $error("squash without trap");

    cause_write_a: assert property (mcause_we |-> trap_exc && !trap_dbg)
        else $error("stray cause write");

    data3_zero_a: assert property (
        csr_en && csr_addr == `HBT_CSR_DATA3 |=> csr_rdata == 32'h0)
        else $error("reserved window not zero");

    // trigger 0 always exists
    load_qual_a: assert property (
        acc_valid && acc_type == HBT_LOAD && !s_r.ctrl[0].r |-> !hit_raw[0])
        else $error("load qualifier ignored");

    user_qual_a: assert property (
        acc_valid && priv_mode == `HBT_PRIV_U && !s_r.ctrl[0].u |-> !hit_raw[0])
        else $error("user qualifier ignored");
endmodule
`default_nettype wire

// file: hbt_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// core pipeline stand-in: one checked access at a time
// ----------------------------------------
module hbt_core_model (
    input wire logic clk,               // core clock
    input wire logic trap_exc,          // breakpoint exception seen
    input wire logic trap_dbg,          // debug entry seen
    output logic acc_valid,             // access strobe
    output hbt_pkg::hbt_acc_e acc_type, // access kind
    output logic [31:0] acc_addr,       // first byte address
    output logic [1:0] acc_size,        // log2 of bytes
    output logic [31:0] acc_pc          // pc, kept as ~addr
);
    import hbt_pkg::*;
    initial begin
        acc_valid = 1'b0;
        acc_type = HBT_LOAD;
        acc_addr = 32'h0;
        acc_size = 2'h0;
        acc_pc = 32'h0;
    end
    // drive for one cycle; the trap answer lands one cycle later
    task automatic access(input int ty, input logic [31:0] a, input int sz,
                          output logic [1:0] res);
        @(negedge clk);
        acc_valid <= 1'b1;
        acc_type <= hbt_acc_e'(ty[1:0]);
        acc_addr <= a;
        acc_size <= sz[1:0];
        acc_pc <= ~a;
        @(negedge clk);
        acc_valid <= 1'b0;
        // released lines must not keep showing the old value
        acc_addr <= ~a;
        acc_pc <= a;
        res = {trap_dbg, trap_exc};
    endtask
endmodule
`default_nettype wire

// file: hart_breakpoint_triggers_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbt_regs.svh"
// ----------------------------------------
// self-checking bench against an integer model
// ----------------------------------------
module hart_breakpoint_triggers_test;
    import hbt_pkg::*;
    logic clk, rst, csr_en, csr_we, dbg_mode, acc_valid;
    logic csr_illegal, trap_exc, trap_dbg, trap_squash, mcause_we;
    logic [11:0] csr_addr;
    logic [31:0] csr_wdata, acc_addr, acc_pc, csr_rdata, mcause, mtval, dpc;
    logic [1:0] priv_mode, acc_size;
    hbt_acc_e acc_type;
    int num_errors = 0;
    int samples_checked = 0;
    logic [31:0] ctl [2]; // model of stored control bits
    logic [31:0] adr [2]; // model of address registers
    logic [31:0] sel = 0, ecause = 0, etval = 0, edpc = 0, seed = 27;
    // ctl0, adr0, ctl1, adr1, base: exact, 4-byte, linked pair, 16-byte
    logic [31:0] cfg [4][5] = '{'{32'h41, 32'h1000, 0, 0, 32'h1000},
        '{32'h10df, 32'h2001, 0, 0, 32'h2000},
        '{32'h95f, 32'h3000, 32'h1df, 32'h3010, 32'h3000},
        '{32'h8c, 32'h4007, 0, 0, 32'h4000}};

    hbt_triggers hbt_triggers_i (.clk, .rst, .csr_en, .csr_we, .csr_addr, .csr_wdata,
        .dbg_mode, .priv_mode, .acc_valid, .acc_type, .acc_addr, .acc_size, .acc_pc,
        .csr_rdata, .csr_illegal, .trap_exc, .trap_dbg, .trap_squash, .mcause_we,
        .mcause, .mtval, .dpc);
    hbt_core_model hbt_core_model_i (.clk, .trap_exc, .trap_dbg, .acc_valid, .acc_type,
        .acc_addr, .acc_size, .acc_pc);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // read view; a debug-owned trigger shows nothing to machine mode
    function automatic logic [31:0] img(logic [11:0] a);
        if (!dbg_mode && ctl[sel[0]][27] && a != `HBT_CSR_SELECT) return 32'h0;
        if (a == `HBT_CSR_SELECT) return sel;
        if (a == `HBT_CSR_DATA1) return 32'h2080_0000 | ctl[sel[0]];
        if (a == `HBT_CSR_DATA2) return adr[sel[0]];
        return 32'h0;
    endfunction

    // one csr access; writes also return the old view
    task automatic op(input logic we, input logic [11:0] a, input logic [31:0] d);
        logic [31:0] e, c;
        logic ill;
        e = img(a);
        ill = !dbg_mode && ctl[sel[0]][27] && a inside {[`HBT_CSR_DATA1:`HBT_CSR_DATA3]};
        @(negedge clk);
        csr_en <= 1'b1;
        csr_we <= we;
        csr_addr <= a;
        csr_wdata <= d;
        @(negedge clk);
        csr_en <= 1'b0;
        check("csr_rdata", csr_rdata, e);
        check("csr_illegal", 32'(csr_illegal), 32'(ill));
        if (we && !ill) begin
            c = d & 32'h0803_ffdf;
            if (d[17:12] > 1) c[17:12] = ctl[sel[0]][17:12];
            if (d[10:7] > 3) c[10:7] = ctl[sel[0]][10:7];
            if (!dbg_mode) c[27] = ctl[sel[0]][27];
            if (a == `HBT_CSR_DATA1) ctl[sel[0]] = c;
            if (a == `HBT_CSR_DATA2) adr[sel[0]] = d;
            if (a == `HBT_CSR_SELECT && d < 2) sel = d;
        end
    endtask

    // predicted {debug, exception} for one access
    function automatic logic [1:0] fire(int ty, int pv, logic [31:0] a, int sz);
        logic [31:0] last, x, lo, span;
        logic [1:0] m, f;
        int n;
        last = a + (32'h1 << sz) - 1;
        for (int t = 0; t < 2; t++) begin
            x = adr[t];
            n = 0;
            while (n < 3 && x[n]) n++;
            span = 32'h2 << n;
            lo = x & ~(span - 1);
            case (ctl[t][10:7])
                4'h0: m[t] = a <= x && x <= last;
                4'h1: m[t] = a < lo + span && last >= lo;
                4'h2: m[t] = last >= x;
                default: m[t] = a < x;
            endcase
            m[t] = m[t] && ctl[t][ty] && ctl[t][pv == 0 ? 3 : pv == 1 ? 4 : 6];
        end
        f[0] = m[0] && !ctl[0][11];
        f[1] = m[1] && !ctl[1][11] && (!ctl[0][11] || m[0]);
        if (dbg_mode) return 2'b00;
        if (f[0] && ctl[0][12] || f[1] && ctl[1][12]) return 2'b10;
        return {1'b0, |f};
    endfunction

    task automatic acc(input int ty, input int pv, input logic [31:0] a, input int sz);
        logic [1:0] e, r;
        e = fire(ty, pv, a, sz);
        @(negedge clk);
        priv_mode <= pv[1:0];
        hbt_core_model_i.access(ty, a, sz, r);
        if (e == 2'b01) ecause = `HBT_CAUSE_BRK;
        if (e == 2'b01) etval = a;
        if (e[1]) edpc = ~a;
        check("trap", 32'(r), 32'(e));
        check("trap_squash", 32'(trap_squash), 32'(|e));
        check("mcause_we", 32'(mcause_we), 32'(e == 2'b01));
        check("mcause", mcause, ecause);
        check("mtval", mtval, etval);
        check("dpc", dpc, edpc);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        print_verdict();
    end

    initial begin
        int p;
        rst = 1'b1;
        {csr_en, csr_we, dbg_mode, csr_addr, csr_wdata} = '0;
        priv_mode = 2'h3;
        ctl = '{0, 0};
        adr = '{0, 0};
        repeat (16) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        for (int t = 0; t < 2; t++) begin
            op(1, `HBT_CSR_SELECT, t);
            op(0, `HBT_CSR_DATA1, 0);
            op(0, `HBT_CSR_DATA3, 0);
        end
        op(1, `HBT_CSR_SELECT, 5);
        op(1, `HBT_CSR_SELECT, 0);
        op(1, `HBT_CSR_DATA1, 32'h000c_5049);
        for (int k = 0; k < 4; k++) begin
            // second half of a linked pair is set up first
            op(1, `HBT_CSR_SELECT, 1);
            op(1, `HBT_CSR_DATA1, cfg[k][2]);
            op(1, `HBT_CSR_DATA2, cfg[k][3]);
            op(1, `HBT_CSR_SELECT, 0);
            op(1, `HBT_CSR_DATA1, cfg[k][0]);
            op(1, `HBT_CSR_DATA2, cfg[k][1]);
            op(0, `HBT_CSR_DATA1, 0);
            acc(0, 3, cfg[k][4], 0);
            acc(2, 0, cfg[k][4] + 1, 3);
            acc(1, 3, cfg[k][4] - 2, 2);
            acc(1, 3, cfg[k][4], 1);
            for (int i = 0; i < 40; i++) begin
                p = xs() % 3;
                acc(xs() % 3, p == 2 ? 3 : p, cfg[k][4] - 8 + xs() % 32, xs() % 4);
            end
        end
        @(negedge clk) dbg_mode = 1'b1;
        acc(0, 3, 32'h4000, 0);
        op(1, `HBT_CSR_SELECT, 1);
        op(1, `HBT_CSR_DATA1, 32'h0800_005f);
        @(negedge clk) dbg_mode = 1'b0;
        op(0, `HBT_CSR_DATA1, 0);
        op(1, `HBT_CSR_DATA2, 32'h5a5a_0000);
        op(0, `HBT_CSR_SELECT, 0);
        @(negedge clk) dbg_mode = 1'b1;
        op(0, `HBT_CSR_DATA1, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
